//--- rtl/dsa_pkg.sv
// Package of constants and types for the dual serial to CSI-2 aggregator
package dsa_pkg;
  // Input modes (two-bit port configuration field)
  localparam logic [1:0] MODE_CSI2_NONSYNC = 2'h0;
  localparam logic [1:0] MODE_RAW12_LF     = 2'h1;
  localparam logic [1:0] MODE_RAW12_HF     = 2'h2;
  localparam logic [1:0] MODE_RAW10        = 2'h3;
  localparam logic [1:0] MODE_CSI2_SYNC    = 2'h3;
  localparam logic [1:0] PORT_MODE_RST     = 2'h0;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_PORT0_CFG = 8'h00;
  localparam logic [7:0] REG_PORT1_CFG = 8'h04;
  localparam logic [7:0] REG_TX_CFG    = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;
  // Port and transmit config fields
  localparam int MODE_LSB   = 0;
  localparam int SRC_BIT    = 2;
  localparam int RAW12_BIT  = 3;
  localparam int R8LSB_BIT  = 4;
  localparam int R8EN_BIT   = 5;
  localparam int VCMAP_LSB  = 8;
  localparam int VC_LSB     = 16;
  localparam int DT_LSB     = 24;
  localparam int SYNC_BIT   = 0;
  localparam int DUAL_BIT   = 1;
  localparam logic [31:0] PORT_CFG_RST = 32'h2B000000;
  localparam logic [31:0] TX_CFG_RST   = 32'h00000000;

  // Frame lengths
  localparam int CSI_FRAME_BITS = 40;
  localparam int RAW_FRAME_BITS = 28;
  // Clock ratios
  localparam int SYNC_LINE_MUL  = 160;
  localparam int SYNC_PCLK_MUL  = 4;
  localparam int SYNC_BC_MUL    = 2;
  localparam int NSYNC_LINE_MUL = 80;
  localparam int NSYNC_BC_MBPS  = 10;
  localparam int LANE_RATE_KBPS = 1662000;
  localparam int RAW10_SYNC_GAP = 10;
  // Strap settle time
  localparam int CLK_MHZ        = 200;
  localparam int STRAP_WAIT_US  = 1000;
  localparam int STRAP_WAIT_CYC = STRAP_WAIT_US * CLK_MHZ;
  // CSI-2 data types
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;
  localparam logic [5:0] DT_LS = 6'h02;
  localparam logic [5:0] DT_LE = 6'h03;

  typedef struct packed {
    logic        valid;
    logic        sop;
    logic        eop;
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic        is_short;
    logic [15:0] data;
  } dsa_pkt_t;

  typedef struct packed {
    logic        valid;
    logic [39:0] bits;
  } dsa_frame_t;
endpackage

//--- rtl/dsa_rx_port.sv
// One receive port: frame decode, VC remap and raw packetising
`timescale 1ns/100ps
module dsa_rx_port
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire dsa_pkg::dsa_frame_t frame,
  input  wire logic [31:0]       cfg,
  input  wire logic [1:0]        mode,
  input  wire logic              take,
  output dsa_pkg::dsa_pkt_t      pkt,
  output logic [7:0]             i2c_fwd,
  output logic [7:0]             diag
);
  typedef struct packed {
    dsa_pkg::dsa_pkt_t pkt;
    logic [7:0]        i2c;
    logic [7:0]        diag;
    logic              hs;
    logic              vs;
    logic              in_line;
  } dsa_rx_st_t;

  dsa_rx_st_t st;
  dsa_rx_st_t next_st;
  logic       raw;
  logic [1:0] vmap;
  logic [1:0] vin;
  logic [15:0] pix;
  logic        hs;
  logic        vs;

  always_comb
  begin
    next_st = st;
    raw  = (mode != dsa_pkg::MODE_CSI2_NONSYNC);
    vin  = frame.bits[33:32];
    vmap = cfg[dsa_pkg::VCMAP_LSB + 2*vin +: 2];
    hs   = frame.bits[12];
    vs   = frame.bits[13];
    pix  = 16'h0000;
    if (!cfg[dsa_pkg::RAW12_BIT])
    begin
      if (cfg[dsa_pkg::R8EN_BIT])
        pix = cfg[dsa_pkg::R8LSB_BIT] ? {8'h00, frame.bits[7:0]}
                                      : {8'h00, frame.bits[9:2]};
      else
        pix = {6'h00, frame.bits[9:0]};
    end
    else
      pix = {4'h0, frame.bits[11:0]};
    if (take)
      next_st.pkt.valid = 1'b0;
    if (frame.valid && !next_st.pkt.valid)
    begin
      if (!raw)
      begin
        next_st.pkt.valid    = 1'b1;
        next_st.pkt.data     = frame.bits[15:0];
        next_st.pkt.dt       = frame.bits[21:16];
        next_st.pkt.sop      = frame.bits[22];
        next_st.pkt.eop      = frame.bits[23];
        next_st.pkt.is_short = frame.bits[24];
        next_st.pkt.vc       = vmap;
        next_st.i2c          = frame.bits[31:24];
        next_st.diag         = frame.bits[39:32];
      end
      else
      begin
        next_st.hs = hs;
        next_st.vs = vs;
        next_st.pkt.vc = cfg[dsa_pkg::VC_LSB +: 2];
        next_st.pkt.valid = 1'b1;
        next_st.pkt.is_short = 1'b1;
        next_st.pkt.sop = 1'b0;
        next_st.pkt.eop = 1'b0;
        next_st.pkt.data = 16'h0000;
        if (vs && !st.vs)
          next_st.pkt.dt = dsa_pkg::DT_FS;
        else if (!vs && st.vs)
          next_st.pkt.dt = dsa_pkg::DT_FE;
        else if (hs && !st.hs)
        begin
          next_st.pkt.dt = dsa_pkg::DT_LS;
          next_st.in_line = 1'b1;
        end
        else if (!hs && st.hs)
        begin
          next_st.pkt.dt  = dsa_pkg::DT_LE;
          next_st.in_line = 1'b0;
        end
        else if (hs)
        begin
          next_st.pkt.is_short = 1'b0;
          next_st.pkt.dt   = cfg[dsa_pkg::DT_LSB +: 6];
          next_st.pkt.data = pix;
        end
        else
          next_st.pkt.valid = 1'b0;
        next_st.pkt.sop = next_st.pkt.is_short || (hs && !st.hs);
        next_st.pkt.eop = next_st.pkt.is_short;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign pkt     = st.pkt;
  assign i2c_fwd = st.i2c;
  assign diag    = st.diag;
endmodule // dsa_rx_port

//--- rtl/dsa_bc_gen.sv
// Back-channel bit-rate strobe generator
`timescale 1ns/100ps
module dsa_bc_gen
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [15:0] div,
  output logic             tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } dsa_bc_st_t;

  dsa_bc_st_t st;
  dsa_bc_st_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= div)
    begin
      next_st.cnt  = 16'h0000;
      next_st.tick = 1'b1;
    end
    else
      next_st.cnt = st.cnt + 16'h0001;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;
endmodule // dsa_bc_gen

//--- rtl/dsa_top.sv
// Top of the dual serial to CSI-2 aggregator with Wishbone registers
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module dsa_top
#(
  parameter int STRAP_WAIT = dsa_pkg::STRAP_WAIT_CYC
)
(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                power_down_n,
  input  wire logic [1:0]          port_input_mode_select,
  input  wire dsa_pkg::dsa_frame_t frame0,
  input  wire dsa_pkg::dsa_frame_t frame1,
  input  wire logic                tx_ready,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output dsa_pkg::dsa_pkt_t        tx_pkt,
  output logic                     tx_dual,
  output logic [2:0]               tx_lanes,
  output logic                     bc_tick,
  output logic [15:0]              bc_div,
  output logic [7:0]               line_mul,
  output logic [7:0]               forward_monitor_output
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} dsa_boot_t;

  typedef struct packed {
    dsa_boot_t         boot;
    logic [31:0]       wait_cnt;
    logic [1:0]        strap;
    logic              strap_ok;
    logic [31:0]       cfg0;
    logic [31:0]       cfg1;
    logic [31:0]       txc;
    logic [31:0]       dat;
    logic              ack;
    logic              owner;
    logic              busy;
    logic              last;
    dsa_pkg::dsa_pkt_t out;
    logic              dual;
    logic [2:0]        lanes;
    logic [15:0]       bdiv;
    logic [7:0]        lmul;
    logic [7:0]        mon;
  } dsa_top_st_t;

  dsa_top_st_t        st;
  dsa_top_st_t        next_st;
  dsa_pkg::dsa_pkt_t  pkt [2];
  logic [7:0]         i2c [2];
  logic [7:0]         dg [2];
  logic [1:0]         take;
  logic [1:0]         pmode [2];
  logic [31:0]        pcfg [2];
  dsa_pkg::dsa_frame_t pfr [2];
  logic               bc_t;
  logic               sel;
  logic [31:0]        wmask;

  assign pfr[0]  = frame0;
  assign pfr[1]  = frame1;
  assign pcfg[0] = st.cfg0;
  assign pcfg[1] = st.cfg1;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      // Strap source or register field per port
      assign pmode[gi] = (pcfg[gi][dsa_pkg::SRC_BIT] && st.strap_ok)
                         ? st.strap
                         : pcfg[gi][dsa_pkg::MODE_LSB +: 2];
      dsa_rx_port u_rx
      (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .frame   (pfr[gi]),
        .cfg     (pcfg[gi]),
        .mode    (pmode[gi]),
        .take    (take[gi]),
        .pkt     (pkt[gi]),
        .i2c_fwd (i2c[gi]),
        .diag    (dg[gi])
      );
    end
  endgenerate

  dsa_bc_gen u_bc
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .div   (st.bdiv),
    .tick  (bc_t)
  );

  always_comb
  begin
    next_st = st;
    take    = 2'b00;
    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Strap sampling after power-down release
    unique case (st.boot)
      ST_IDLE:
        if (power_down_n)
        begin
          next_st.boot     = ST_WAIT;
          next_st.wait_cnt = 32'h00000000;
        end
      ST_WAIT:
        if (!power_down_n)
          next_st.boot = ST_IDLE;
        else if (st.wait_cnt >= STRAP_WAIT - 1)
        begin
          next_st.strap    = port_input_mode_select;
          next_st.strap_ok = 1'b1;
          next_st.boot     = ST_RUN;
        end
        else
          next_st.wait_cnt = st.wait_cnt + 32'h00000001;
      ST_RUN:
        if (!power_down_n)
        begin
          next_st.boot     = ST_IDLE;
          next_st.strap_ok = 1'b0;
        end
    endcase
    // Wishbone classic slave, one wait state
    next_st.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !st.ack)
    begin
      next_st.ack = 1'b1;
      next_st.dat = 32'h00000000;
      unique case (wb_adr_i)
        dsa_pkg::REG_PORT0_CFG:
          next_st.dat = st.cfg0;
        dsa_pkg::REG_PORT1_CFG:
          next_st.dat = st.cfg1;
        dsa_pkg::REG_TX_CFG:
          next_st.dat = st.txc;
        dsa_pkg::REG_STATUS:
          next_st.dat = {16'h0000, dg[1], pmode[1], pmode[0],
                         st.strap_ok, st.owner, st.busy, 1'b0};
        default:
          next_st.dat = 32'h00000000;
      endcase
    end
    // Write lands at the edge where the master sees the answer
    if (wb_cyc_i && wb_stb_i && wb_we_i && st.ack)
    begin
      unique case (wb_adr_i)
        dsa_pkg::REG_PORT0_CFG:
          next_st.cfg0 = (st.cfg0 & ~wmask) | (wb_dat_i & wmask);
        dsa_pkg::REG_PORT1_CFG:
          next_st.cfg1 = (st.cfg1 & ~wmask) | (wb_dat_i & wmask);
        dsa_pkg::REG_TX_CFG:
          next_st.txc = (st.txc & ~wmask) | (wb_dat_i & wmask);
        default:
          next_st.txc = st.txc;
      endcase
    end
    // Transmit configuration
    next_st.dual  = st.txc[dsa_pkg::DUAL_BIT];
    next_st.lanes = st.txc[dsa_pkg::DUAL_BIT] ? 3'h2 : 3'h4;
    if (st.txc[dsa_pkg::SYNC_BIT])
    begin
      next_st.lmul = 8'(dsa_pkg::SYNC_LINE_MUL);
      next_st.bdiv = 16'(dsa_pkg::CLK_MHZ / (dsa_pkg::SYNC_BC_MUL * 25) - 1);
    end
    else
    begin
      next_st.lmul = 8'(dsa_pkg::NSYNC_LINE_MUL);
      next_st.bdiv = 16'(dsa_pkg::CLK_MHZ / dsa_pkg::NSYNC_BC_MBPS - 1);
    end
    next_st.mon = i2c[st.owner] ^ dg[0];
    // Packet-boundary arbitration
    sel = st.busy ? st.owner
                  : (pkt[st.last ^ 1'b1].valid ? ~st.last : st.last);
    if (!st.out.valid || tx_ready)
    begin
      next_st.out.valid = 1'b0;
      if (pkt[sel].valid)
      begin
        next_st.out   = pkt[sel];
        take[sel]     = 1'b1;
        next_st.owner = sel;
        next_st.busy  = !pkt[sel].eop;
        if (pkt[sel].eop)
          next_st.last = sel;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st      <= '0;
      st.boot <= ST_IDLE;
      st.cfg0 <= dsa_pkg::PORT_CFG_RST;
      st.cfg1 <= dsa_pkg::PORT_CFG_RST;
      st.txc  <= dsa_pkg::TX_CFG_RST;
    end
    else
      st <= next_st;
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign tx_pkt   = st.out;
  assign tx_dual  = st.dual;
  assign tx_lanes = st.lanes;
  assign bc_tick  = bc_t;
  assign bc_div   = st.bdiv;
  assign line_mul = st.lmul;
  assign forward_monitor_output = st.mon;
endmodule // dsa_top

//--- sim/dsa_top_sva.sv
// Checker of the aggregator top ports
`timescale 1ns/100ps
module dsa_top_sva
#(
  parameter int STRAP_WAIT = 20
)
(
  input wire logic                mclk,
  input wire logic                rst_b,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire dsa_pkg::dsa_frame_t frame0,
  input wire dsa_pkg::dsa_frame_t frame1,
  input wire logic                tx_ready,
  input wire dsa_pkg::dsa_pkt_t   tx_pkt,
  input wire logic                tx_dual,
  input wire logic [2:0]          tx_lanes,
  input wire logic                bc_tick,
  input wire logic [15:0]         bc_div,
  input wire logic [7:0]          line_mul
);
  typedef struct packed {
    logic [15:0] cfg0;
    logic        sync;
    logic        lk;
    logic [1:0]  lvc;
    logic [15:0] ldiv;
    logic [16:0] gap;
  } dsa_chk_t;
  dsa_chk_t   s;
  dsa_chk_t   next_s;
  logic [1:0] vmap;
  logic       wr;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Shadow of written config, open packet and tick spacing
  assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign vmap = s.cfg0[8 + 2 * frame0.bits[33:32] +: 2];
  always_comb
  begin
    next_s = s;
    if (wr && wb_adr_i == dsa_pkg::REG_PORT0_CFG)
      next_s.cfg0 = wb_dat_i[15:0];
    if (wr && wb_adr_i == dsa_pkg::REG_TX_CFG)
      next_s.sync = wb_dat_i[dsa_pkg::SYNC_BIT];
    if (tx_pkt.valid && tx_ready && tx_pkt.sop)
      next_s.lvc = tx_pkt.vc;
    if (tx_pkt.valid && tx_ready && (tx_pkt.sop || tx_pkt.eop))
      next_s.lk = !tx_pkt.eop;
    next_s.ldiv = bc_div;
    next_s.gap  = (bc_tick || bc_div != s.ldiv) ? '0 : s.gap + 17'h1;
  end
  always_ff @(posedge mclk or negedge rst_b)
    s <= !rst_b ? '0 : next_s;

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not one cycle");
  property p_unmap;
    wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C})
      |-> wb_dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_lanes;
    $past(rst_b) |-> tx_lanes == (tx_dual ? 3'h2 : 3'h4);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("lane count wrong");
  property p_mul;
    $past(rst_b) && $stable(s.sync) |-> line_mul == (s.sync ? 8'hA0 : 8'h50);
  endproperty
  a_mul: assert property (p_mul)
    else $error("line multiplier wrong");
  property p_hold;
    tx_pkt.valid && !tx_ready |=> $stable(tx_pkt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("packet changed while stalled");
  property p_fwd;
    frame0.valid && !frame1.valid && !tx_pkt.valid && tx_ready
      && s.cfg0[2:0] == 3'h0 && !$past(frame0.valid) && !$past(frame1.valid)
      ##1 tx_ready |=> tx_pkt.valid && tx_pkt.data == $past(frame0.bits[15:0], 2)
      && tx_pkt.dt == $past(frame0.bits[21:16], 2) && tx_pkt.vc == $past(vmap, 2);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forwarded packet wrong");
  property p_unsplit;
    tx_pkt.valid && s.lk |-> tx_pkt.vc == s.lvc;
  endproperty
  a_unsplit: assert property (p_unsplit)
    else $error("packet split by other port");
  property p_bc;
    s.gap <= {1'b0, bc_div} + 17'h2;
  endproperty
  a_bc: assert property (p_bc)
    else $error("back channel tick missing");

  c_fwd: cover property (frame0.valid ##2 tx_pkt.valid);
  c_stall: cover property (tx_pkt.valid && !tx_ready);
  c_dual: cover property (tx_dual);
endmodule // dsa_top_sva

//--- sim/dsa_link_model.sv
// Partner model: serializer frame source and CSI-2 receiver sink
`timescale 1ns/100ps
module dsa_link_model
(
  input  wire logic              mclk,
  input  wire dsa_pkg::dsa_pkt_t tx_pkt,
  output dsa_pkg::dsa_frame_t    frame0,
  output dsa_pkg::dsa_frame_t    frame1,
  output logic                   tx_ready
);
  logic              slow = 1'b0;
  dsa_pkg::dsa_pkt_t got[$];

  initial
  begin
    frame0   = '0;
    frame1   = '0;
    tx_ready = 1'b1;
  end

  // Sink takes a packet when valid meets ready; slow mode stalls
  always @(posedge mclk)
  begin
    if (tx_pkt.valid && tx_ready)
      got.push_back(tx_pkt);
    tx_ready <= slow ? !tx_ready : 1'b1;
  end

  // One frame pulse, then lines show the inverse of the last value
  task automatic send(input int port, input logic [39:0] bits);
    if (port == 0)
      frame0 <= '{1'b1, bits};
    else
      frame1 <= '{1'b1, bits};
    @(posedge mclk);
    if (port == 0)
      frame0 <= '{1'b0, ~bits};
    else
      frame1 <= '{1'b0, ~bits};
    repeat (6) @(posedge mclk);
  endtask
endmodule // dsa_link_model

//--- sim/dsa_top_tb_top.sv
// Testbench top of the aggregator
`timescale 1ns/100ps
module dsa_top_tb_top;
  logic                mclk, rst_b, power_down_n, tx_ready, tx_dual, bc_tick;
  logic                wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [1:0]          port_input_mode_select;
  logic [2:0]          tx_lanes;
  logic [3:0]          wb_sel_i;
  logic [5:0]          dt;
  logic [7:0]          wb_adr_i, line_mul;
  logic [15:0]         bc_div;
  logic [31:0]         wb_dat_i, wb_dat_o;
  dsa_pkg::dsa_frame_t frame0, frame1;
  dsa_pkg::dsa_pkt_t   tx_pkt, p;
  int                  num_errors = 0;
  int                  checked = 0;

  dsa_top #(.STRAP_WAIT(20)) i_dsa_top (.mclk, .rst_b, .power_down_n,
    .port_input_mode_select, .frame0, .frame1, .tx_ready, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .tx_pkt, .tx_dual, .tx_lanes, .bc_tick, .bc_div, .line_mul,
    .forward_monitor_output());
  dsa_link_model i_dsa_link_model (.mclk, .tx_pkt, .frame0, .frame1,
    .tx_ready);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task automatic pop(output dsa_pkg::dsa_pkt_t r);
    check(i_dsa_link_model.got.size() > 0, 32'h1);
    r = '0;
    if (i_dsa_link_model.got.size() > 0)
      r = i_dsa_link_model.got.pop_front();
  endtask

  initial
  begin
    rst_b = 1'b0;
    power_down_n = 1'b0;
    port_input_mode_select = dsa_pkg::MODE_RAW10;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    power_down_n <= 1'b1;
    @(posedge mclk);
    rd(dsa_pkg::REG_PORT0_CFG, dsa_pkg::PORT_CFG_RST);
    rd(dsa_pkg::REG_PORT1_CFG, dsa_pkg::PORT_CFG_RST);
    rd(dsa_pkg::REG_TX_CFG, dsa_pkg::TX_CFG_RST);
    rd(8'hF0, 32'h0);
    wr(dsa_pkg::REG_PORT0_CFG, 32'h2C011B00);
    rd(dsa_pkg::REG_PORT0_CFG, 32'h2C011B00);
    wr(dsa_pkg::REG_PORT1_CFG, 32'h2B00E400);
    $display("Test registers done");
    for (int v = 3; v >= 0; v--)
    begin
      wr(dsa_pkg::REG_TX_CFG, 32'(v));
      repeat (2) @(posedge mclk);
      check({tx_dual, tx_lanes, line_mul}, {v[1], v[1] ? 3'h2 : 3'h4,
            v[0] ? 8'hA0 : 8'h50});
    end
    $display("Test transmit config done");
    for (int i = 0; i < 5; i++)
    begin
      dt = (i < 4) ? dsa_pkg::DT_FS + 6'(i) : 6'h12;
      i_dsa_link_model.send(0, {6'h0, 2'(i), 7'h0, i < 4, 2'b11, dt,
                                16'hA5C0 + 16'(i)});
      pop(p);
      check({p.vc, p.dt, p.sop, p.eop, p.is_short, p.data}, {2'(3 - i), dt,
            2'b11, i < 4, 16'hA5C0 + 16'(i)});
    end
    $display("Test packet forwarding done");
    i_dsa_link_model.slow = 1'b1;
    fork
      i_dsa_link_model.send(0, {8'h1, 10'h1, 6'h2B, 16'h1111});
      begin
        @(posedge mclk);
        i_dsa_link_model.send(1, {8'h1, 10'h3, 6'h2B, 16'h2222});
      end
    join
    i_dsa_link_model.send(0, {8'h1, 10'h2, 6'h2B, 16'h3333});
    repeat (12) @(posedge mclk);
    pop(p);
    check({p.vc, p.data}, {2'h2, 16'h1111});
    pop(p);
    check({p.vc, p.data}, {2'h2, 16'h3333});
    pop(p);
    check({p.vc, p.data}, {2'h1, 16'h2222});
    i_dsa_link_model.slow = 1'b0;
    $display("Test arbitration done");
    wr(dsa_pkg::REG_PORT0_CFG, 32'h2C01FF04);
    power_down_n <= 1'b0;
    @(posedge mclk);
    power_down_n <= 1'b1;
    repeat (30) @(posedge mclk);
    repeat (3) i_dsa_link_model.send(0, 40'h3055);
    i_dsa_link_model.send(0, 40'h2055);
    pop(p);
    check(p.vc, 32'h1);
    i_dsa_link_model.got.delete();
    $display("Test strap mode done");
    for (int m = 1; m < 4; m++)
    begin
      wr(dsa_pkg::REG_PORT1_CFG, {8'h2C, 6'h0, 2'h2, 8'hE4, 4'h0, m != 3,
         1'b0, 2'(m)});
      for (int j = 0; j < 36; j++)
        i_dsa_link_model.send(1, {26'h0, j < 24, j < 12,
                                  12'h100 + 12'(j)});
      check(i_dsa_link_model.got.size() > 0, 32'h1);
      while (i_dsa_link_model.got.size() > 0)
      begin
        p = i_dsa_link_model.got.pop_front();
        check(p.vc, 32'h2);
      end
    end
    $display("Test raw modes done");
    summarize();
  end
endmodule // dsa_top_tb_top

bind dsa_top dsa_top_sva #(.STRAP_WAIT(STRAP_WAIT)) i_dsa_top_sva (.mclk,
  .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .frame0, .frame1, .tx_ready, .tx_pkt, .tx_dual, .tx_lanes,
  .bc_tick, .bc_div, .line_mul);
